// File: inc/irc_pkg.sv
// Purpose: shared constants, types and helpers of the interrupt controller
// Assumes: one system clock, active-low reset
// Notes:   offsets, field positions, counts and the software word reset values except alt's live here
`default_nettype none

package irc_pkg;

	localparam int NUM_SRC    = 45;
	localparam int NUM_TRAP   = 8;
	localparam int WORD_W     = 16;
	localparam int FLAG_WORDS = 3;
	localparam int FLAG_W     = FLAG_WORDS * WORD_W;
	localparam int PRIO_REGS  = 12;
	localparam int NUM_EXT    = 5;
	localparam int TEMPORARY_IRQ_DISABLE_W     = 14;
	localparam int PC_W       = 24;

	// three level bits per nibble; last register holds only its low byte
	localparam logic [15:0] PRIO_MASK_FULL = 16'h7777;
	localparam logic [15:0] PRIO_MASK_LAST = 16'h0077;
	localparam logic [15:0] PRIO_RST       = 16'h4444;
	localparam logic [47:0] FLAG_MASK      = 48'h1FFF_FFFF_FFFF;
	localparam logic [47:0] FLAG_RST       = 48'h0000_0000_0000;

	localparam logic [2:0]  LVL_NMI      = 3'h7;
	localparam logic [3:0]  LVL_TRAP     = 4'h8;
	localparam logic [5:0]  VEC_SRC_BASE = 6'h08;
	localparam logic [6:0]  VT_ENTRIES   = 7'h3F;
	localparam logic [23:0] VT_FIRST     = 24'h000004;
	localparam logic [23:0] VT_LAST      = 24'h0000FE;

	// global control word a / b field positions
	localparam int          GCA_GIE_BIT   = 15;
	localparam int          GCB_ALT_BIT   = 15;
	localparam int          GCB_TEMPORARY_IRQ_DISABLE_BIT  = 14;
	localparam int          TRAP_ADDR_ERR = 3;
	localparam logic        GIE_RST       = 1'b1;
	localparam logic [7:0]  TRAP_RST      = 8'h00;
	localparam logic [4:0]  EXT_CFG_RST   = 5'h00;
	localparam logic [13:0] TEMPORARY_IRQ_DISABLE_RST      = 14'h0000;

	// external request pins map onto these source numbers
	localparam int EXT_SRC_IDX [NUM_EXT] = '{0, 16, 23, 36, 37};

	typedef enum logic [1:0] {
		G_IDLE,
		G_WAIT
	} irc_guard_st_type;

	function automatic logic [2:0] src_level(input logic [PRIO_REGS*WORD_W-1:0] prio, input int idx);
		src_level = prio[idx*4 +: 3];
	endfunction

	function automatic logic in_vector_space(input logic [PC_W-1:0] addr);
		in_vector_space = (addr >= VT_FIRST) && (addr <= VT_LAST);
	endfunction

endpackage

`default_nettype wire

// File: logic/irc_arbiter.sv
// Purpose: picks the single winning trap or interrupt request
// Assumes: pending = flag and enable, computed by the caller
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module irc_arbiter
	import irc_pkg::*;
(
	// clock for the checks only
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	// request state
	input  wire logic [NUM_SRC-1:0]            pend_i,
	input  wire logic [PRIO_REGS*WORD_W-1:0]   prio_i,
	input  wire logic [NUM_TRAP-1:0]           trap_i,
	input  wire logic [2:0]                    ipl_i,
	input  wire logic                          gie_i,
	input  wire logic                          temporary_irq_disable_i,
	// winner
	output logic                               win_valid_o,
	output logic [5:0]                         win_vec_o,
	output logic [3:0]                         win_lvl_o
);

	typedef struct packed {
		logic       valid;
		logic [5:0] vec;
		logic [3:0] lvl;
	} irc_win_type;

	irc_win_type win_c;
	logic [NUM_SRC-1:0] elig_c;

	always_comb begin
		win_c = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			// level 7 ignores the mask and the global enable, not the timed disable
			elig_c[i] = pend_i[i] && !temporary_irq_disable_i && ((src_level(prio_i, i) == LVL_NMI) || //RQ13
				(gie_i && (src_level(prio_i, i) > ipl_i))); //RQ22 RQ23 RQ7
		end
		// strict compare: on equal level the lower vector stays
		for (int i = 0; i < NUM_SRC; i++) begin
			if (elig_c[i] && (!win_c.valid || ({1'b0, src_level(prio_i, i)} > win_c.lvl))) begin //RQ21 RQ12
				win_c.valid = 1'b1;
				win_c.vec   = VEC_SRC_BASE + 6'(i);
				win_c.lvl   = {1'b0, src_level(prio_i, i)};
			end
		end
		// traps outrank every source; lowest trap vector first
		for (int t = NUM_TRAP - 1; t >= 0; t--) begin
			if (trap_i[t]) begin //RQ1
				win_c.valid = 1'b1;
				win_c.vec   = 6'(t);
				win_c.lvl   = LVL_TRAP;
			end
		end
	end

	assign win_valid_o = win_c.valid;
	assign win_vec_o   = win_c.vec;
	assign win_lvl_o   = win_c.lvl;

	// helper: no lower-numbered eligible source shares the winning level
	logic tie_ok_c;
	always_comb begin
		tie_ok_c = 1'b1;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (elig_c[i] && (VEC_SRC_BASE + 6'(i) < win_c.vec) && ({1'b0, src_level(prio_i, i)} == win_c.lvl))
				tie_ok_c = 1'b0;
		end
	end

	natural_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ21
		(win_c.valid && win_c.lvl != LVL_TRAP) |-> tie_ok_c)
		else $error("lower vector at same level lost arbitration");

	trap_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ1
		(|trap_i) |-> (win_c.valid && win_c.lvl == LVL_TRAP && trap_i[win_c.vec[2:0]]))
		else $error("pending trap not chosen first");

endmodule

`default_nettype wire

// File: logic/irc_top.sv
// Purpose: central interrupt pre-processor: flags, enables, levels, arbitration
// Assumes: source events and pins are synchronous to clk_sys_i
// Notes:   software reaches the words through plain write strobes and read ports
// Notes on behaviour
// [RQ1] arbitrate 45 sources plus 8 traps
// [RQ2] vector word reaches pc via 24-bit mux
// [RQ3] the primary table starts at word 0x000004; the alternate table starts at word 0x000082
// [RQ4] flags set by source, cleared by software
// [RQ5] only enabled flags may be serviced
// [RQ6] twelve level registers, last one 8 bits
// [RQ7] core 3-bit level masks requests
// [RQ8] control a: global enable, trap flags
// [RQ9] control b: external pins, alternate table
// [RQ10] flags set regardless of any enable
// [RQ11] software clears flag before enabling source
// [RQ12] each source takes level 0 to 7
// [RQ13] levels 0-6 maskable, 7 non-maskable
// [RQ14] trigger options live in the peripherals
// [RQ15] timed disable blocks all levels, bit 14 set
// [RQ16] serviced vector word loads the pc
// [RQ17] 63 vectors between 0x000004 and 0x0000FE
// [RQ18] fetch inside vector space raises address error
// [RQ19] jump into vector space raises address error
// [RQ20] level in low 3 nibble bits, top zero
// [RQ21] same level: lower vector number wins
// [RQ22] present only above core level, or level 7
// [RQ23] global enable off masks all maskable requests
`timescale 1ns/1ps
`default_nettype none

module irc_top
	import irc_pkg::*;
(
	// clock and reset
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	// request sources
	input  wire logic [NUM_SRC-1:0]            src_event_i,
	input  wire logic [NUM_EXT-1:0]            ext_pin_i,
	input  wire logic [NUM_TRAP-1:0]           trap_event_i,
	// software writes
	input  wire logic [15:0]                   sw_wdata_i,
	input  wire logic [FLAG_WORDS-1:0]         flag_wr_i,
	input  wire logic [FLAG_WORDS-1:0]         enable_wr_i,
	input  wire logic [PRIO_REGS-1:0]          prio_wr_i,
	input  wire logic                          gca_wr_i,
	input  wire logic                          gcb_wr_i,
	// software reads
	output logic [15:0]                        request_flags_word0_o,
	output logic [15:0]                        request_flags_word1_o,
	output logic [15:0]                        request_flags_word2_o,
	output logic [15:0]                        source_enable_word0_o,
	output logic [15:0]                        source_enable_word1_o,
	output logic [15:0]                        source_enable_word2_o,
	output logic [PRIO_REGS-1:0][15:0]         source_priority_o,
	output logic [15:0]                        global_control_a_o,
	output logic [15:0]                        global_control_b_o,
	// processor core
	input  wire logic [2:0]                    cpu_priority_level_i,
	input  wire logic                          temporary_irq_disable_start_i,
	input  wire logic [TEMPORARY_IRQ_DISABLE_W-1:0]             temporary_irq_disable_count_i,
	input  wire logic                          instr_done_i,
	input  wire logic                          core_take_i,
	output logic                               irq_valid_o,
	output logic [5:0]                         irq_vector_o,
	output logic [3:0]                         irq_level_o,
	// vector fetch and program counter
	input  wire logic                          pdata_valid_i,
	input  wire logic [PC_W-1:0]               pdata_i,
	input  wire logic [PC_W-1:0]               pc_seq_i,
	output logic                               vec_rd_o,
	output logic [PC_W-1:0]                    vec_addr_o,
	output logic                               pc_load_o,
	output logic [PC_W-1:0]                    pc_value_o,
	// vector space guard
	input  wire logic                          fetch_valid_i,
	input  wire logic [PC_W-1:0]               fetch_addr_i,
	input  wire logic                          jump_valid_i,
	input  wire logic [PC_W-1:0]               jump_target_i
);

	typedef struct packed {
		logic [FLAG_W-1:0]          flags;
		logic [FLAG_W-1:0]          enable;
		logic [PRIO_REGS-1:0][15:0] prio;
		logic                       global_irq_enable;
		logic [NUM_TRAP-1:0]        traps;
		logic                       alt;
		logic [NUM_EXT-1:0]         ext_fall;
		logic [NUM_EXT-1:0]         ext_prev;
		logic [TEMPORARY_IRQ_DISABLE_W-1:0]          temporary_irq_disable_cnt;
		logic                       irq_valid;
		logic [5:0]                 irq_vec;
		logic [3:0]                 irq_lvl;
	} irc_state_type;

	irc_state_type s_q, s_d;

	logic [1:0]          rst_sync_q;
	logic                rst_n;
	logic [FLAG_W-1:0]   src_set_c;
	logic [NUM_TRAP-1:0] trap_set_c;
	logic                addr_err;
	logic                win_valid;
	logic [5:0]          win_vec;
	logic [3:0]          win_lvl;
	logic                temporary_irq_disable_active;

	// release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign temporary_irq_disable_active = (s_q.temporary_irq_disable_cnt != TEMPORARY_IRQ_DISABLE_RST);

	always_comb begin
		s_d = s_q;
		// source events arrive already qualified by their own peripheral
		src_set_c = {{(FLAG_W - NUM_SRC){1'b0}}, src_event_i}; //RQ14
		for (int e = 0; e < NUM_EXT; e++) begin
			if (ext_pin_i[e] != s_q.ext_prev[e] && ext_pin_i[e] != s_q.ext_fall[e]) //RQ9
				src_set_c[EXT_SRC_IDX[e]] = 1'b1;
		end
		s_d.ext_prev = ext_pin_i;
		// software may write either value; a set in the same cycle wins
		for (int w = 0; w < FLAG_WORDS; w++) begin
			if (flag_wr_i[w])
				s_d.flags[w*WORD_W +: WORD_W] = sw_wdata_i; //RQ4
			if (enable_wr_i[w])
				s_d.enable[w*WORD_W +: WORD_W] = sw_wdata_i; //RQ5
		end
		s_d.flags  = (s_d.flags | src_set_c) & FLAG_MASK; //RQ10 RQ4
		s_d.enable = s_d.enable & FLAG_MASK;
		for (int r = 0; r < PRIO_REGS; r++) begin
			if (prio_wr_i[r])
				s_d.prio[r] = sw_wdata_i & ((r == PRIO_REGS - 1) ? PRIO_MASK_LAST : PRIO_MASK_FULL); //RQ6 RQ20
		end
		// trap flags: software writes zero to clear, hardware set wins
		trap_set_c = trap_event_i;
		trap_set_c[TRAP_ADDR_ERR] = trap_event_i[TRAP_ADDR_ERR] | addr_err; //RQ18 RQ19
		if (gca_wr_i) begin
			s_d.global_irq_enable   = sw_wdata_i[GCA_GIE_BIT]; //RQ8
			s_d.traps = s_q.traps & sw_wdata_i[NUM_TRAP-1:0];
		end
		s_d.traps = s_d.traps | trap_set_c; //RQ8
		if (gcb_wr_i) begin
			s_d.alt      = sw_wdata_i[GCB_ALT_BIT]; //RQ9
			s_d.ext_fall = sw_wdata_i[NUM_EXT-1:0];
		end
		// timed disable counts retired instructions down to zero
		if (temporary_irq_disable_start_i)
			s_d.temporary_irq_disable_cnt = temporary_irq_disable_count_i; //RQ15
		else if (instr_done_i && temporary_irq_disable_active)
			s_d.temporary_irq_disable_cnt = s_q.temporary_irq_disable_cnt - 14'h0001;
		s_d.irq_valid = win_valid;
		s_d.irq_vec   = win_vec;
		s_d.irq_lvl   = win_lvl;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			// last level register keeps only its low byte, reset value included
			s_q <= '{flags: FLAG_RST, enable: FLAG_RST,
				prio: {PRIO_RST & PRIO_MASK_LAST, {(PRIO_REGS - 1){PRIO_RST & PRIO_MASK_FULL}}}, //RQ6
				global_irq_enable: GIE_RST, traps: TRAP_RST, alt: 1'b0, ext_fall: EXT_CFG_RST, ext_prev: 5'h00,
				temporary_irq_disable_cnt: TEMPORARY_IRQ_DISABLE_RST, irq_valid: 1'b0, irq_vec: 6'h00, irq_lvl: 4'h0};
		end else begin
			s_q <= s_d;
		end
	end

	irc_arbiter u_arbiter (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n),
		.pend_i      (s_q.flags[NUM_SRC-1:0] & s_q.enable[NUM_SRC-1:0]), //RQ5
		.prio_i      (s_q.prio),
		.trap_i      (s_q.traps),
		.ipl_i       (cpu_priority_level_i), //RQ7
		.gie_i       (s_q.global_irq_enable),
		.temporary_irq_disable_i      (temporary_irq_disable_active), //RQ15
		.win_valid_o (win_valid),
		.win_vec_o   (win_vec),
		.win_lvl_o   (win_lvl)
	);

	irc_vector_guard u_guard (
		.clk_sys_i     (clk_sys_i),
		.rst_n_i       (rst_n),
		.take_i        (core_take_i && s_q.irq_valid),
		.take_vec_i    (s_q.irq_vec),
		.alt_i         (s_q.alt),
		.pdata_valid_i (pdata_valid_i),
		.pdata_i       (pdata_i),
		.pc_seq_i      (pc_seq_i),
		.vec_rd_o      (vec_rd_o),
		.vec_addr_o    (vec_addr_o),
		.pc_load_o     (pc_load_o),
		.pc_value_o    (pc_value_o),
		.fetch_valid_i (fetch_valid_i),
		.fetch_addr_i  (fetch_addr_i),
		.jump_valid_i  (jump_valid_i),
		.jump_target_i (jump_target_i),
		.addr_err_o    (addr_err)
	);

	assign request_flags_word0_o = s_q.flags[15:0];
	assign request_flags_word1_o = s_q.flags[31:16];
	assign request_flags_word2_o = s_q.flags[47:32];
	assign source_enable_word0_o = s_q.enable[15:0];
	assign source_enable_word1_o = s_q.enable[31:16];
	assign source_enable_word2_o = s_q.enable[47:32];
	assign source_priority_o     = s_q.prio;
	assign global_control_a_o    = {s_q.global_irq_enable, 7'h00, s_q.traps};
	assign global_control_b_o    = {s_q.alt, temporary_irq_disable_active, 9'h000, s_q.ext_fall}; //RQ15
	assign irq_valid_o           = s_q.irq_valid;
	assign irq_vector_o          = s_q.irq_vec;
	assign irq_level_o           = s_q.irq_lvl;

	sequence src_event_s;
		|src_event_i;
	endsequence

	flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ10
		src_event_s |=> ((s_q.flags[NUM_SRC-1:0] & $past(src_event_i)) == $past(src_event_i)))
		else $error("source event did not set its flag");

	flag_sw_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ4
		(|($past(s_q.flags[15:0]) & ~s_q.flags[15:0])) |-> $past(flag_wr_i[0]))
		else $error("flag word 0 cleared without a software write");

	enable_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ5
		(irq_valid_o && irq_level_o != LVL_TRAP) |->
		(|($past(s_q.enable[NUM_SRC-1:0] & s_q.flags[NUM_SRC-1:0]) &
		({{(NUM_SRC - 1){1'b0}}, 1'b1} << (irq_vector_o - VEC_SRC_BASE)))))
		else $error("disabled or idle source presented");

	level_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ22
		(irq_valid_o && irq_level_o < {1'b0, LVL_NMI}) |-> (irq_level_o > {1'b0, $past(cpu_priority_level_i)}))
		else $error("maskable request not above core level");

	gie_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ23
		$past(!s_q.global_irq_enable) |-> !(irq_valid_o && irq_level_o < {1'b0, LVL_NMI}))
		else $error("maskable request with global enable off");

	temporary_irq_disable_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ15
		$past(temporary_irq_disable_active) |-> ((!irq_valid_o || irq_level_o == LVL_TRAP) && $past(global_control_b_o[GCB_TEMPORARY_IRQ_DISABLE_BIT])))
		else $error("request presented during timed disable");

	prio_zero_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ20
		((source_priority_o[PRIO_REGS-1] & ~PRIO_MASK_LAST) == 16'h0000) && ((source_priority_o[0] & ~PRIO_MASK_FULL) == 16'h0000))
		else $error("unused level bits read non-zero");

	nmi_taken_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) //RQ13
		(!temporary_irq_disable_active && s_q.flags[0] && s_q.enable[0] && src_level(s_q.prio, 0) == LVL_NMI && !temporary_irq_disable_start_i)
		|=> (irq_valid_o && irq_level_o >= {1'b0, LVL_NMI}))
		else $error("level 7 request not presented");

endmodule

`default_nettype wire

// File: logic/irc_vector_guard.sv
// Purpose: vector fetch, program counter input mux, vector space guard
// Assumes: core asks for a vector only for the presented winner
// Notes:   fetches during a vector read in progress are exempt from the guard; jumps are not
`timescale 1ns/1ps
`default_nettype none

module irc_vector_guard
	import irc_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_i,
	input  wire logic            rst_n_i,
	// vector fetch
	input  wire logic            take_i,
	input  wire logic [5:0]      take_vec_i,
	input  wire logic            alt_i,
	input  wire logic            pdata_valid_i,
	input  wire logic [PC_W-1:0] pdata_i,
	input  wire logic [PC_W-1:0] pc_seq_i,
	output logic                 vec_rd_o,
	output logic [PC_W-1:0]      vec_addr_o,
	output logic                 pc_load_o,
	output logic [PC_W-1:0]      pc_value_o,
	// guard
	input  wire logic            fetch_valid_i,
	input  wire logic [PC_W-1:0] fetch_addr_i,
	input  wire logic            jump_valid_i,
	input  wire logic [PC_W-1:0] jump_target_i,
	output logic                 addr_err_o
);

	typedef struct packed {
		irc_guard_st_type st;
		logic             vec_rd;
		logic [PC_W-1:0]  vec_addr;
		logic             pc_load;
		logic [PC_W-1:0]  pc_value;
		logic             addr_err;
	} irc_guard_type;

	irc_guard_type s_q, s_d;
	logic [6:0] slot_c;

	always_comb begin
		s_d          = s_q;
		s_d.pc_load  = 1'b0;
		// alternate table follows the primary one entry for entry
		slot_c       = {1'b0, take_vec_i} + (alt_i ? VT_ENTRIES : 7'h00);
		s_d.pc_value = pc_seq_i; //RQ2
		unique case (s_q.st)
			G_IDLE: begin
				if (take_i) begin
					s_d.st       = G_WAIT;
					s_d.vec_rd   = 1'b1;
					s_d.vec_addr = VT_FIRST + {16'h0000, slot_c, 1'b0}; //RQ3 RQ17
				end
			end
			G_WAIT: begin
				if (pdata_valid_i) begin
					s_d.st       = G_IDLE;
					s_d.vec_rd   = 1'b0;
					s_d.pc_load  = 1'b1;
					s_d.pc_value = pdata_i; //RQ2 RQ16
				end
			end
		endcase
		// a stray fetch or jump into the table never executes table data
		s_d.addr_err = (fetch_valid_i && in_vector_space(fetch_addr_i) && s_q.st == G_IDLE) || //RQ18
			(jump_valid_i && in_vector_space(jump_target_i)); //RQ19
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '{st: G_IDLE, vec_addr: VT_FIRST, pc_value: 24'h000000, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign vec_rd_o   = s_q.vec_rd;
	assign vec_addr_o = s_q.vec_addr;
	assign pc_load_o  = s_q.pc_load;
	assign pc_value_o = s_q.pc_value;
	assign addr_err_o = s_q.addr_err;

	sequence vec_start_s;
		take_i && s_q.st == G_IDLE;
	endsequence

	sequence vec_read_s;
		vec_rd_o && (vec_addr_o >= VT_FIRST) && (vec_addr_o <= VT_LAST);
	endsequence

	vec_read_range_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ17
		vec_start_s |=> vec_read_s)
		else $error("vector read address outside the table");

	pc_mux_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ16
		(vec_rd_o && pdata_valid_i) |=> (pc_load_o && pc_value_o == $past(pdata_i) && !vec_rd_o))
		else $error("vector word did not reach the program counter");

	fetch_guard_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ18
		(fetch_valid_i && in_vector_space(fetch_addr_i) && !vec_rd_o) |=> addr_err_o)
		else $error("fetch from vector space raised no address error");

	jump_guard_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) //RQ19
		(jump_valid_i && !in_vector_space(jump_target_i) && !fetch_valid_i) |=> !addr_err_o ##0
		$past(jump_valid_i && in_vector_space(jump_target_i), 1) == 1'b0)
		else $error("address error without a cause");

endmodule

`default_nettype wire

// File: test/irc_core_model.sv
// Purpose: core side model that answers vector table reads
// Assumes: one vector read outstanding at a time
// Notes:   table word is 0x010000 plus the entry address
`timescale 1ns/1ps
`default_nettype none

module irc_core_model
	import irc_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_i,
	input  wire logic            rst_n_i,
	// program data bus
	input  wire logic            vec_rd_i,
	input  wire logic [PC_W-1:0] vec_addr_i,
	input  wire logic [1:0]      lat_i,
	output logic                 pdata_valid_o,
	output logic [PC_W-1:0]      pdata_o
);
	logic [1:0] wait_q;

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 2'h0;
			pdata_valid_o <= 1'b0;
			pdata_o <= 24'h000000;
		end else if (pdata_valid_o) begin
			pdata_valid_o <= 1'b0;
			pdata_o <= ~pdata_o;
		end else if (vec_rd_i && wait_q == lat_i) begin
			pdata_valid_o <= 1'b1;
			pdata_o <= 24'h010000 | vec_addr_i;
			wait_q <= 2'h0;
		end else begin
			// released bus toggles so a stale word never passes
			pdata_o <= ~pdata_o;
			wait_q <= vec_rd_i ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

`default_nettype wire

// File: test/irc_top_test.sv
// Purpose: directed checks of flags, levels, masking, fetch and guard
// Assumes: inputs change at the falling edge
// Notes:   expected words worked out by hand from field positions
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module irc_top_test
	import irc_pkg::*;
;
	logic clk_sys_i = 0, rst_n_i = 0, gca_wr_i = 0, gcb_wr_i = 0, temporary_irq_disable_start_i = 0, instr_done_i = 0;
	logic core_take_i = 0, fetch_valid_i = 0, jump_valid_i = 0;
	logic [NUM_SRC-1:0] src_event_i = '0;
	logic [NUM_EXT-1:0] ext_pin_i = '0;
	logic [NUM_TRAP-1:0] trap_event_i = '0;
	logic [15:0] sw_wdata_i = 16'h0000;
	logic [FLAG_WORDS-1:0] flag_wr_i = '0, enable_wr_i = '0;
	logic [PRIO_REGS-1:0] prio_wr_i = '0;
	logic [2:0] cpu_priority_level_i = 3'h0;
	logic [TEMPORARY_IRQ_DISABLE_W-1:0] temporary_irq_disable_count_i = 14'h0002;
	logic [PC_W-1:0] pc_seq_i = 24'h000200, fetch_addr_i = 24'h000100, jump_target_i = 24'h0000FE;
	logic [1:0] lat = 2'h0;
	logic [15:0] request_flags_word0_o, request_flags_word1_o, request_flags_word2_o, source_enable_word0_o;
	logic [15:0] source_enable_word1_o, source_enable_word2_o, global_control_a_o, global_control_b_o;
	logic [PRIO_REGS-1:0][15:0] source_priority_o;
	logic irq_valid_o, vec_rd_o, pc_load_o, pdata_valid_i;
	logic [5:0] irq_vector_o;
	logic [3:0] irq_level_o;
	logic [PC_W-1:0] pdata_i, vec_addr_o, pc_value_o;
	int fail_count = 0, num_checks = 0, cycles = 0;

	irc_top i_irc_top (.clk_sys_i, .rst_n_i, .src_event_i, .ext_pin_i, .trap_event_i, .sw_wdata_i, .flag_wr_i,
		.enable_wr_i, .prio_wr_i, .gca_wr_i, .gcb_wr_i, .request_flags_word0_o, .request_flags_word1_o,
		.request_flags_word2_o, .source_enable_word0_o, .source_enable_word1_o, .source_enable_word2_o,
		.source_priority_o, .global_control_a_o, .global_control_b_o, .cpu_priority_level_i, .temporary_irq_disable_start_i,
		.temporary_irq_disable_count_i, .instr_done_i, .core_take_i, .irq_valid_o, .irq_vector_o, .irq_level_o, .pdata_valid_i,
		.pdata_i, .pc_seq_i, .vec_rd_o, .vec_addr_o, .pc_load_o, .pc_value_o, .fetch_valid_i, .fetch_addr_i,
		.jump_valid_i, .jump_target_i);
	irc_core_model i_irc_core_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .vec_rd_i(vec_rd_o),
		.vec_addr_i(vec_addr_o), .lat_i(lat), .pdata_valid_o(pdata_valid_i), .pdata_o(pdata_i));

	initial forever #2 clk_sys_i = ~clk_sys_i;

	task tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task wr(input int k, input int i, input logic [15:0] d);
		sw_wdata_i = d;
		case (k)
			0: flag_wr_i[i] = 1'b1;
			1: enable_wr_i[i] = 1'b1;
			2: prio_wr_i[i] = 1'b1;
			3: gca_wr_i = 1'b1;
			default: gcb_wr_i = 1'b1;
		endcase
		tick(1);
		{flag_wr_i, enable_wr_i, prio_wr_i, gca_wr_i, gcb_wr_i} = '0;
	endtask

	task pulse_src(input int s);
		src_event_i[s] = 1'b1;
		tick(1);
		src_event_i[s] = 1'b0;
	endtask

	task take_vec(input logic [23:0] ea);
		int n;
		core_take_i = 1'b1;
		tick(1);
		core_take_i = 1'b0;
		`CHK(vec_addr_o, ea)
		n = 0;
		while (pc_load_o !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		`CHK(pc_value_o, 24'h010000 | ea)
	endtask

	task conclude;
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		tick(10);
		rst_n_i = 1'b1;
		tick(3);
		`CHK(global_control_a_o, 16'h8000)
		`CHK(source_priority_o[11], 16'h0044)
		`CHK(pc_value_o, 24'h000200)
		wr(2, 0, 16'hFFFF);
		`CHK(source_priority_o[0], 16'h7777)
		wr(2, 11, 16'hFFFF);
		`CHK(source_priority_o[11], 16'h0077)
		pulse_src(3);
		`CHK(request_flags_word0_o, 16'h0008)
		tick(1);
		`CHK(irq_valid_o, 1'b0)
		wr(1, 0, 16'h000A);
		tick(1);
		`CHK({irq_valid_o, irq_vector_o, irq_level_o}, {1'b1, 6'h0B, 4'h7})
		wr(2, 0, 16'h5050);
		cpu_priority_level_i = 3'h2;
		tick(1);
		`CHK({irq_valid_o, irq_level_o}, {1'b1, 4'h5})
		cpu_priority_level_i = 3'h5;
		tick(1);
		`CHK(irq_valid_o, 1'b0)
		cpu_priority_level_i = 3'h4;
		pulse_src(1);
		tick(1);
		`CHK(irq_vector_o, 6'h09)
		wr(3, 0, 16'h0000);
		pulse_src(2);
		`CHK(request_flags_word0_o, 16'h000E)
		`CHK(irq_valid_o, 1'b0)
		wr(2, 0, 16'h7050);
		cpu_priority_level_i = 3'h7;
		tick(1);
		`CHK({irq_valid_o, irq_vector_o}, {1'b1, 6'h0B})
		temporary_irq_disable_start_i = 1'b1;
		tick(1);
		temporary_irq_disable_start_i = 1'b0;
		`CHK(global_control_b_o, 16'h4000)
		tick(1);
		`CHK(irq_valid_o, 1'b0)
		instr_done_i = 1'b1;
		tick(2);
		instr_done_i = 1'b0;
		tick(1);
		`CHK({global_control_b_o[14], irq_valid_o}, 2'b01)
		wr(3, 0, 16'h8000);
		cpu_priority_level_i = 3'h0;
		take_vec(24'h00001A);
		lat = 2'h3;
		wr(4, 0, 16'h8000);
		take_vec(24'h000098);
		wr(0, 0, 16'h0000);
		tick(1);
		`CHK({request_flags_word0_o, irq_valid_o}, 17'h00000)
		fetch_valid_i = 1'b1;
		tick(1);
		fetch_addr_i = 24'h000004;
		tick(1);
		fetch_valid_i = 1'b0;
		tick(2);
		`CHK(global_control_a_o, 16'h8008)
		tick(1);
		`CHK({irq_vector_o, irq_level_o}, {6'h03, LVL_TRAP})
		wr(3, 0, 16'h8000);
		jump_valid_i = 1'b1;
		tick(1);
		jump_valid_i = 1'b0;
		trap_event_i = 8'h20;
		tick(1);
		trap_event_i = 8'h00;
		tick(2);
		`CHK({global_control_a_o, irq_vector_o}, {16'h8028, 6'h03})
		wr(3, 0, 16'h8000);
		jump_target_i = 24'h000200;
		jump_valid_i = 1'b1;
		tick(1);
		jump_valid_i = 1'b0;
		tick(2);
		`CHK(global_control_a_o, 16'h8000)
		wr(0, 0, 16'h0000);
		wr(1, 0, 16'h0001);
		wr(2, 0, 16'h0007);
		ext_pin_i[0] = 1'b1;
		tick(4);
		`CHK(request_flags_word0_o, 16'h0001)
		`CHK({irq_valid_o, irq_vector_o, irq_level_o}, {1'b1, 6'h08, 4'h7})
		conclude();
	end
endmodule

`default_nettype wire
